// ==== src/qrp_pkg.sv ====
// Constants for the quasi-resonant switch-off and protection block.
// Assumes a 40 MHz ref_clk and an AXI4-Lite register port of 32 bits.
package qrp_pkg;
	// Clock period in picoseconds.
	localparam int CLK_PERIOD_PS = 25000;
	// Leading-edge blanking time in ns, least time, rounded up.
	localparam int EDGE_BLANK_TIME_NS = 280;
	localparam int EDGE_BLANK_CYC =
		(EDGE_BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Short-winding spike blanking time in ns, least time, rounded up.
	localparam int SHORT_WINDING_BLANK_TIME_NS = 190;
	localparam int SHORT_WINDING_BLANK_CYC =
		(SHORT_WINDING_BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;
	// Overvoltage blanking time in ns, least time, rounded up.
	localparam int AUX_OVP_BLANK_TIME_NS = 1000;
	localparam int AUX_OVP_BLANK_CYC =
		(AUX_OVP_BLANK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Ringing suppression time in ns, least time, rounded up.
	localparam int RING_SUPP_TIME_NS = 2500;
	localparam int RING_SUPP_CYC =
		(RING_SUPP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Maximum on-time in ns, longest time, rounded down.
	localparam int MAX_ON_TIME_NS = 25000;
	localparam int MAX_ON_CYC = MAX_ON_TIME_NS * 1000 / CLK_PERIOD_PS;
	// Maximum switching period in ns (20 kHz floor), rounded down.
	localparam int MAX_PERIOD_TIME_NS = 50000;
	localparam int MAX_PERIOD_CYC = MAX_PERIOD_TIME_NS * 1000 / CLK_PERIOD_PS;
	// Counter width for the timing counters.
	localparam int TIMER_W = 16;
	// Zero-crossing counter ceiling.
	localparam logic [2:0] ZC_MAX = 3'h7;
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
	localparam logic [7:0] ADDR_LIMIT_CFG = 8'h10;
	// Control register: bit 0 enables switching.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Limit configuration: [7:0] top limit, [15:8] current threshold.
	localparam int LIM_MAX_LSB = 0;
	localparam int LIM_THR_LSB = 8;
	localparam logic [7:0] LIM_MAX_RESET = 8'hFF;
	localparam logic [7:0] LIM_THR_RESET = 8'h40;
	// Interrupt event bit positions.
	localparam int EV_LATCH = 0;
	localparam int EV_OVERLOAD = 1;
	localparam int EV_MAINS_UV = 2;
	localparam int EV_CUR_LIMIT = 3;
	localparam int EV_MAX_ON = 4;
	localparam int EV_W = 5;
	localparam logic [EV_W-1:0] INT_MASK_RESET = 5'h00;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Protection sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SOFT,
		ST_RUN,
		ST_OVERLOAD,
		ST_MAINS_UV,
		ST_LATCH
	} qrp_state_e;
endpackage : qrp_pkg

// ==== src/qrp_spike_filter.sv ====
// Qualifier that passes a comparator level only after it has stood high.
// Assumes the raw input is synchronous to ref_clk.
`timescale 1ns/1ps
module qrp_spike_filter #(
	parameter int HOLD_CYC = 8,
	parameter int CNT_W = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Qualification window and raw level.
	input wire logic arm,
	input wire logic raw,
	// Qualified level.
	output logic hit
);
	logic [CNT_W-1:0] cnt;

	// The count restarts whenever the level drops or the window closes.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (!(arm && raw)) begin
			cnt <= '0;
		end else if (cnt != CNT_W'(HOLD_CYC)) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign hit = arm && raw && (cnt == CNT_W'(HOLD_CYC));
endmodule : qrp_spike_filter

// ==== src/qrp_switch_off.sv ====
// Switch-off and protection sequencer of a quasi-resonant flyback controller.
// Assumes comparator outputs arrive synchronous to ref_clk and that an
// AXI4-Lite master reaches the registers.
//
// Summary of operation
// - Gate latch resets once scaled sense (3.3 x Vcs + 0.7) exceeds feedback.
// - Gate is forced low after standing high for the maximum on-time.
// - Gate turns off at once when the current-limit comparator trips.
// - Current-limit trips are ignored during edge blanking after turn-on.
// - Short-winding trip (1.68V) during on-time enters latched-off state.
// - Short-winding trip must stand through its blank time before acting.
// - Current limit is lowered by the aux pin current above its threshold.
// - Supply undervoltage resets internal state and holds the gate off.
// - Blank-cap charge turns on at overload, off at cap high or fb release.
// - Cap above its high threshold trips overload: gate off, fb pulled up.
// - After overload, wait for cap below low threshold, then soft start.
// - Aux overvoltage during switch-off time enters latched-off state.
// - Mains sense low blocks the gate; in soft start or run it also enables the hysteresis source.
// - Recovery from mains undervoltage always goes through soft start.
// - After ringing suppression, turn-on needs zc count >= up/down value or the maximum period to elapse.
`timescale 1ns/1ps
module qrp_switch_off
	import qrp_pkg::*;
#(
	parameter int MAX_ON_CYCLES = MAX_ON_CYC,
	parameter int MAX_PERIOD_CYCLES = MAX_PERIOD_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Comparator levels.
	input wire logic pwm_trip,
	input wire logic cur_limit_trip,
	input wire logic short_winding_trip,
	input wire logic aux_ovp_trip,
	input wire logic supply_uv,
	input wire logic fb_overload,
	input wire logic fb_below_release,
	input wire logic blank_cap_high,
	input wire logic blank_cap_low,
	input wire logic mains_low,
	// Switch-on inputs.
	input wire logic zero_cross,
	input wire logic [2:0] updown_value,
	input wire logic soft_start_done,
	// Digitised aux pin current.
	input wire logic [7:0] aux_pin_current,
	// Power stage and analog controls.
	output logic gate,
	output logic blank_cap_charge_source,
	output logic fb_pullup,
	output logic mains_hysteresis_source,
	output logic soft_start_active,
	output logic [7:0] cs_limit_level,
	// AXI4-Lite slave.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt.
	output logic irq
);
	qrp_state_e state;
	qrp_state_e next_state;
	logic next_gate;
	logic [TIMER_W-1:0] on_cnt;
	logic [TIMER_W-1:0] off_cnt;
	logic [TIMER_W-1:0] period_cnt;
	logic [2:0] zc_cnt;
	logic sw_ok;
	logic leb_done;
	logic ring_done;
	logic max_on_hit;
	logic cl_hit;
	logic turn_on;
	logic turn_off;
	logic sw_hit;
	logic ovp_hit;
	logic [31:0] ctrl;
	logic [7:0] lim_max;
	logic [7:0] lim_thr;
	logic [EV_W-1:0] int_stat;
	logic [EV_W-1:0] int_mask;
	logic [EV_W-1:0] ev;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [EV_W-1:0] w1c;
	logic [7:0] excess;

	////////////////////////////////////////////////////////////////////////
	// Comparator qualification.

	// Short-winding trip counts only while the gate is on.
	qrp_spike_filter #(
		.HOLD_CYC(SHORT_WINDING_BLANK_CYC),
		.CNT_W(8)
	) u_sw_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.arm(gate),
		.raw(short_winding_trip),
		.hit(sw_hit)
	);

	// Overvoltage is watched during the off time only.
	qrp_spike_filter #(
		.HOLD_CYC(AUX_OVP_BLANK_CYC),
		.CNT_W(8)
	) u_ovp_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.arm(!gate && sw_ok),
		.raw(aux_ovp_trip),
		.hit(ovp_hit)
	);

	////////////////////////////////////////////////////////////////////////
	// Gate timing.

	assign sw_ok = (state == ST_SOFT) || (state == ST_RUN);
	assign leb_done = on_cnt >= TIMER_W'(EDGE_BLANK_CYC);
	assign cl_hit = cur_limit_trip && leb_done;
	assign max_on_hit = on_cnt >= TIMER_W'(MAX_ON_CYCLES - 1);
	assign ring_done = off_cnt >= TIMER_W'(RING_SUPP_CYC);
	assign turn_off = pwm_trip || cl_hit || max_on_hit;
	assign turn_on = ring_done && ((zc_cnt >= updown_value) ||
		(period_cnt >= TIMER_W'(MAX_PERIOD_CYCLES)));

	// Gate flip-flop: set by the switch-on logic, reset by switch-off.
	always_comb begin
		next_gate = gate;
		if (!sw_ok || (next_state != ST_SOFT && next_state != ST_RUN)) begin
			next_gate = 1'b0;
		end else if (gate) begin
			if (turn_off) begin
				next_gate = 1'b0;
			end
		end else if (turn_on) begin
			next_gate = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || supply_uv) begin
			gate <= 1'b0;
		end else begin
			gate <= next_gate;
		end
	end

	// On-time counter, restarted at each turn-on.
	always_ff @(posedge ref_clk) begin
		if (!rstn || !gate) begin
			on_cnt <= '0;
		end else if (on_cnt != '1) begin
			on_cnt <= on_cnt + 1'b1;
		end
	end

	// Off-time counter for ringing suppression.
	always_ff @(posedge ref_clk) begin
		if (!rstn || gate) begin
			off_cnt <= '0;
		end else if (off_cnt != '1) begin
			off_cnt <= off_cnt + 1'b1;
		end
	end

	// Period counter since the last turn-on.
	always_ff @(posedge ref_clk) begin
		if (!rstn || (next_gate && !gate)) begin
			period_cnt <= '0;
		end else if (period_cnt != '1) begin
			period_cnt <= period_cnt + 1'b1;
		end
	end

	// Zero crossings counted after ringing suppression, cleared at turn-on.
	always_ff @(posedge ref_clk) begin
		if (!rstn || gate) begin
			zc_cnt <= '0;
		end else if (zero_cross && ring_done && zc_cnt != ZC_MAX) begin
			zc_cnt <= zc_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection sequencer.

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (ctrl[CTRL_ENABLE_BIT] && !mains_low) begin
					next_state = ST_SOFT;
				end
			end
			ST_SOFT, ST_RUN: begin
				if (sw_hit || ovp_hit) begin
					next_state = ST_LATCH;
				end else if (blank_cap_high) begin
					next_state = ST_OVERLOAD;
				end else if (mains_low) begin
					next_state = ST_MAINS_UV;
				end else if (!ctrl[CTRL_ENABLE_BIT]) begin
					next_state = ST_IDLE;
				end else if (state == ST_SOFT && soft_start_done) begin
					next_state = ST_RUN;
				end
			end
			ST_OVERLOAD: begin
				if (blank_cap_low) begin
					next_state = ST_SOFT;
				end
			end
			ST_MAINS_UV: begin
				if (!mains_low) begin
					next_state = ST_SOFT;
				end
			end
			ST_LATCH: begin
				next_state = ST_LATCH;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || supply_uv) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Blank-cap charge source enable.
	always_ff @(posedge ref_clk) begin
		if (!rstn || supply_uv || !sw_ok) begin
			blank_cap_charge_source <= 1'b0;
		end else if (blank_cap_high || fb_below_release) begin
			blank_cap_charge_source <= 1'b0;
		end else if (fb_overload) begin
			blank_cap_charge_source <= 1'b1;
		end
	end

	assign fb_pullup = (state == ST_OVERLOAD);
	assign mains_hysteresis_source = (state == ST_MAINS_UV);
	assign soft_start_active = (state == ST_SOFT);

	////////////////////////////////////////////////////////////////////////
	// Line-dependent current limit.

	assign excess = (aux_pin_current > lim_thr) ?
		(aux_pin_current - lim_thr) : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cs_limit_level <= LIM_MAX_RESET;
		end else if (lim_max > excess) begin
			cs_limit_level <= lim_max - excess;
		end else begin
			cs_limit_level <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt events.

	always_comb begin
		ev = '0;
		ev[EV_LATCH] = (state != ST_LATCH) && (next_state == ST_LATCH);
		ev[EV_OVERLOAD] = (state != ST_OVERLOAD) &&
			(next_state == ST_OVERLOAD);
		ev[EV_MAINS_UV] = (state != ST_MAINS_UV) &&
			(next_state == ST_MAINS_UV);
		ev[EV_CUR_LIMIT] = gate && cl_hit;
		ev[EV_MAX_ON] = gate && max_on_hit;
	end

	// Write one to clear; a new event in the same cycle wins.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			int_stat <= '0;
		end else begin
			int_stat <= (int_stat & ~w1c) | ev;
		end
	end

	assign irq = |(int_stat & int_mask);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path.

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign w1c = (do_write && aw_addr == ADDR_INT_STAT && w_strb[0]) ?
		w_data[EV_W-1:0] : '0;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_addr)
				ADDR_CTRL, ADDR_STATUS, ADDR_INT_STAT, ADDR_INT_MASK,
				ADDR_LIMIT_CFG: s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl <= CTRL_RESET;
		end else if (do_write && aw_addr == ADDR_CTRL && w_strb[0]) begin
			ctrl <= {24'h00_0000, w_data[7:0]} & CTRL_RESET;
		end
	end

	// Interrupt mask register.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			int_mask <= INT_MASK_RESET;
		end else if (do_write && aw_addr == ADDR_INT_MASK && w_strb[0]) begin
			int_mask <= w_data[EV_W-1:0];
		end
	end

	// Current limit configuration register.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lim_max <= LIM_MAX_RESET;
			lim_thr <= LIM_THR_RESET;
		end else if (do_write && aw_addr == ADDR_LIMIT_CFG) begin
			if (w_strb[0]) begin
				lim_max <= w_data[LIM_MAX_LSB +: 8];
			end
			if (w_strb[1]) begin
				lim_thr <= w_data[LIM_THR_LSB +: 8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path.

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= ctrl;
				ADDR_STATUS: s_axi_rdata <= {16'h0000, cs_limit_level,
					1'b0, 3'(state), blank_cap_charge_source, fb_pullup,
					mains_hysteresis_source, gate};
				ADDR_INT_STAT: s_axi_rdata <= {27'h000_0000, int_stat};
				ADDR_INT_MASK: s_axi_rdata <= {27'h000_0000, int_mask};
				ADDR_LIMIT_CFG: s_axi_rdata <= {16'h0000, lim_thr, lim_max};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : qrp_switch_off

// ==== test/qrp_power_stage.sv ====
// Behavioural power switch, sense ramp and aux winding ringing.
// Assumes the gate is a register on ref_clk.
`timescale 1ns/1ps
module qrp_power_stage (
	// Clock and gate.
	input wire logic ref_clk,
	input wire logic gate,
	// On-time before the sense ramp crosses feedback; FF crosses after 255 cycles.
	input wire logic [7:0] on_len,
	// Sense outputs.
	output logic pwm_trip,
	output logic zero_cross
);
	logic [7:0] cnt = 8'h00;
	logic [4:0] ring = 5'h00;
	always_ff @(posedge ref_clk) begin
		cnt <= gate ? cnt + 8'h01 : 8'h00;
		ring <= (gate || ring == 5'h13) ? 5'h00 : ring + 5'h01;
	end
	// Ramp crosses after on_len cycles; ringing crosses every 20 off cycles.
	assign pwm_trip = gate && cnt >= on_len;
	assign zero_cross = !gate && ring == 5'h0A;
endmodule : qrp_power_stage

// ==== test/qrp_switch_off_assertions.sv ====
// Port-level checks of the switch-off and protection block.
// Assumes it is bound into qrp_switch_off.
`timescale 1ns/1ps
module qrp_switch_off_assertions
	import qrp_pkg::*;
#(
	parameter int MAX_ON_CYCLES = MAX_ON_CYC
) (
	// Watched ports.
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pwm_trip,
	input wire logic cur_limit_trip,
	input wire logic short_winding_trip,
	input wire logic supply_uv,
	input wire logic fb_below_release,
	input wire logic blank_cap_high,
	input wire logic blank_cap_low,
	input wire logic mains_low,
	input wire logic gate,
	input wire logic blank_cap_charge_source,
	input wire logic fb_pullup,
	input wire logic mains_hysteresis_source,
	input wire logic soft_start_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic [15:0] on_c;
	logic [7:0] off_c;
	logic [3:0] sw_c;
	// Consecutive cycles of short-winding trip with the gate high.
	always_ff @(posedge ref_clk) begin
		if (!rstn || !(gate && short_winding_trip)) begin
			sw_c <= 4'h0;
		end else if (sw_c != 4'hF) begin
			sw_c <= sw_c + 4'h1;
		end
	end
	// Gate-high and gate-low cycle counts.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			on_c <= 16'h0000;
			off_c <= 8'hFF;
		end else begin
			on_c <= gate ? on_c + 16'h0001 : 16'h0000;
			off_c <= gate ? 8'h00 : off_c + {7'h00, off_c != 8'hFF};
		end
	end
	property p_pwm; gate && pwm_trip |=> !gate; endproperty
	a_pwm: assert property (p_pwm) else $error("gate on after trip");
	property p_max_on; gate |-> on_c < MAX_ON_CYCLES; endproperty
	a_max_on: assert property (p_max_on) else $error("on too long");
	property p_cur;
		gate && cur_limit_trip && on_c >= EDGE_BLANK_CYC |=> !gate;
	endproperty
	a_cur: assert property (p_cur) else $error("limit ignored");
	property p_leb;
		gate && cur_limit_trip && on_c < EDGE_BLANK_CYC && !pwm_trip &&
		!supply_uv && !blank_cap_high && !mains_low && !short_winding_trip
		|=> gate;
	endproperty
	a_leb: assert property (p_leb) else $error("blanked trip acted");
	property p_sw; gate && short_winding_trip && sw_c == 4'h8 |=> !gate;
	endproperty
	a_sw: assert property (p_sw) else $error("no latch off");
	property p_uv; supply_uv |=> !gate && !blank_cap_charge_source;
	endproperty
	a_uv: assert property (p_uv) else $error("uv left gate on");
	property p_chg;
		blank_cap_high || fb_below_release |=> !blank_cap_charge_source;
	endproperty
	a_chg: assert property (p_chg) else $error("charge stayed on");
	property p_olp;
		fb_pullup && !supply_uv && !blank_cap_low |=> fb_pullup && !gate;
	endproperty
	a_olp: assert property (p_olp) else $error("overload left");
	property p_mains;
		mains_hysteresis_source && !supply_uv && !mains_low
		|=> soft_start_active && !gate;
	endproperty
	a_mains: assert property (p_mains) else $error("no soft start");
	property p_ring; !gate && off_c < 8'h63 |=> !gate; endproperty
	a_ring: assert property (p_ring) else $error("early turn-on");
endmodule : qrp_switch_off_assertions
bind qrp_switch_off qrp_switch_off_assertions #(
	.MAX_ON_CYCLES(MAX_ON_CYCLES)) u_chk (.ref_clk, .rstn, .pwm_trip,
	.cur_limit_trip, .short_winding_trip, .supply_uv, .fb_below_release,
	.blank_cap_high, .blank_cap_low, .mains_low, .gate,
	.blank_cap_charge_source, .fb_pullup, .mains_hysteresis_source,
	.soft_start_active);

// ==== test/qrp_switch_off_tb.sv ====
// Self-checking bench of the switch-off and protection block.
// Assumes the power stage model and an AXI4-Lite master in this bench.
`timescale 1ns/1ps
module qrp_switch_off_tb
	import qrp_pkg::*;
;
	localparam int MAXON = 50;
	logic ref_clk = 1'b0, rstn = 1'b0, cur_limit_trip = 1'b0;
	logic short_winding_trip = 1'b0, aux_ovp_trip = 1'b0, supply_uv = 1'b0;
	logic fb_overload = 1'b0, fb_below_release = 1'b0, blank_cap_high = 1'b0;
	logic blank_cap_low = 1'b1, mains_low = 1'b0, soft_start_done = 1'b1;
	logic [2:0] updown_value = 3'h1;
	logic [7:0] aux_pin_current = 8'h00, on_len = 8'h03;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pwm_trip, zero_cross;
	logic gate, blank_cap_charge_source, fb_pullup, mains_hysteresis_source;
	logic soft_start_active, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [7:0] cs_limit_level;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int bad_count = 0, num_checks = 0, cycles = 0, n, m;
	always #12.5 ref_clk = ~ref_clk;
	qrp_switch_off #(.MAX_ON_CYCLES(MAXON), .MAX_PERIOD_CYCLES(200)) dut (
		.ref_clk, .rstn, .pwm_trip, .cur_limit_trip, .short_winding_trip,
		.aux_ovp_trip, .supply_uv, .fb_overload, .fb_below_release,
		.blank_cap_high, .blank_cap_low, .mains_low, .zero_cross,
		.updown_value, .soft_start_done, .aux_pin_current, .gate,
		.blank_cap_charge_source, .fb_pullup, .mains_hysteresis_source,
		.soft_start_active, .cs_limit_level, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	qrp_power_stage ps (.ref_clk, .gate, .on_len, .pwm_trip, .zero_cross);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chb
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic at, wt;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		at = 1'b0;
		wt = 1'b0;
		while (!(at && wt)) begin
			@(negedge ref_clk);
			at = at || s_axi_awready === 1'b1;
			wt = wt || s_axi_wready === 1'b1;
			@(posedge ref_clk);
			if (at) s_axi_awvalid <= 1'b0;
			if (wt) s_axi_wvalid <= 1'b0;
		end
		do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic state(input logic [2:0] e);
		axi_rd(ADDR_STATUS);
		chk({29'h0, d[6:4]}, {29'h0, e});
	endtask : state
	// Length of the next full gate period at level lvl.
	task automatic meas(input logic lvl, output int k);
		k = 0;
		do @(negedge ref_clk); while (gate !== ~lvl);
		do @(negedge ref_clk); while (gate !== lvl);
		while (gate === lvl) begin
			k++;
			@(negedge ref_clk);
		end
	endtask : meas
	task automatic t_regs;
		axi_rd(ADDR_CTRL);
		chk(d, CTRL_RESET);
		axi_rd(ADDR_INT_MASK);
		chk(d, {27'h0, INT_MASK_RESET});
		axi_rd(ADDR_LIMIT_CFG);
		chk(d, {16'h0, LIM_THR_RESET, LIM_MAX_RESET});
		axi_rd(8'h20);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		axi_wr(8'h20, 32'h1, RESP_SLVERR);
		axi_wr(ADDR_STATUS, 32'h0, RESP_OKAY);
		axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		cyc(2);
		state(3'h0);
		chb(gate, 1'b0);
		axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
	endtask : t_regs
	task automatic t_zc;
		meas(1'b0, n);
		@(posedge ref_clk);
		updown_value <= 3'h3;
		meas(1'b0, m);
		chk(m - n, 40);
		@(posedge ref_clk);
		updown_value <= 3'h7;
		meas(1'b0, m);
		chk(m, 197);
		@(posedge ref_clk);
		updown_value <= 3'h1;
	endtask : t_zc
	task automatic t_on(input logic [7:0] len, input int e);
		@(posedge ref_clk);
		on_len <= len;
		meas(1'b1, n);
		chk(n, e);
		@(posedge ref_clk);
		on_len <= 8'h03;
	endtask : t_on
	task automatic t_irq;
		axi_wr(ADDR_INT_MASK, 32'h1 << EV_MAX_ON, RESP_OKAY);
		t_on(8'hFF, MAXON);
		chb(irq, 1'b1);
		axi_rd(ADDR_INT_STAT);
		chk(d, 32'h1 << EV_MAX_ON);
		axi_wr(ADDR_INT_MASK, 32'h0, RESP_OKAY);
		chb(irq, 1'b0);
		axi_wr(ADDR_INT_STAT, 32'h1 << EV_MAX_ON, RESP_OKAY);
		axi_rd(ADDR_INT_STAT);
		chk(d, 32'h0);
		@(posedge ref_clk);
		cur_limit_trip <= 1'b1;
		t_on(8'hFF, EDGE_BLANK_CYC + 1);
		cur_limit_trip <= 1'b0;
		axi_rd(ADDR_INT_STAT);
		chb(d[EV_CUR_LIMIT], 1'b1);
	endtask : t_irq
	task automatic t_fold(input logic [7:0] aux, input logic [7:0] e);
		@(posedge ref_clk);
		aux_pin_current <= aux;
		cyc(3);
		chk({24'h0, cs_limit_level}, {24'h0, e});
	endtask : t_fold
	task automatic t_olp;
		@(posedge ref_clk);
		soft_start_done <= 1'b0;
		fb_overload <= 1'b1;
		cyc(3);
		chb(blank_cap_charge_source, 1'b1);
		@(posedge ref_clk);
		fb_below_release <= 1'b1;
		cyc(2);
		chb(blank_cap_charge_source, 1'b0);
		@(posedge ref_clk);
		fb_below_release <= 1'b0;
		blank_cap_low <= 1'b0;
		blank_cap_high <= 1'b1;
		cyc(3);
		chk({fb_pullup, gate, blank_cap_charge_source}, 32'h4);
		@(posedge ref_clk);
		fb_overload <= 1'b0;
		blank_cap_high <= 1'b0;
		cyc(300);
		chb(fb_pullup, 1'b1);
		@(posedge ref_clk);
		blank_cap_low <= 1'b1;
		cyc(2);
		chb(soft_start_active, 1'b1);
		@(posedge ref_clk);
		mains_low <= 1'b1;
		cyc(3);
		chb(mains_hysteresis_source, 1'b1);
		cyc(300);
		chb(gate, 1'b0);
		@(posedge ref_clk);
		mains_low <= 1'b0;
		cyc(2);
		chb(soft_start_active, 1'b1);
		@(posedge ref_clk);
		soft_start_done <= 1'b1;
	endtask : t_olp
	task automatic t_latch(input logic ovp);
		@(posedge ref_clk);
		on_len <= 8'hFF;
		do @(negedge ref_clk); while (gate !== 1'b1);
		@(posedge ref_clk);
		short_winding_trip <= !ovp;
		repeat (8) @(posedge ref_clk);
		short_winding_trip <= 1'b0;
		state(3'h2);
		do @(negedge ref_clk); while (gate !== 1'b1);
		@(posedge ref_clk);
		short_winding_trip <= !ovp;
		aux_ovp_trip <= ovp;
		cyc(300);
		state(3'h5);
		@(posedge ref_clk);
		short_winding_trip <= 1'b0;
		aux_ovp_trip <= 1'b0;
		cyc(300);
		state(3'h5);
		@(posedge ref_clk);
		supply_uv <= 1'b1;
		@(posedge ref_clk);
		supply_uv <= 1'b0;
		t_on(8'h03, 4);
	endtask : t_latch
	initial begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_on(8'h03, 4);
		t_zc();
		t_irq();
		t_fold(8'h50, 8'hEF);
		axi_wr(ADDR_LIMIT_CFG, 32'h2080, RESP_OKAY);
		t_fold(8'h10, 8'h80);
		t_fold(8'h50, 8'h50);
		t_fold(8'hB0, 8'h00);
		t_olp();
		t_latch(1'b0);
		t_latch(1'b1);
		tally_and_finish();
	end
endmodule : qrp_switch_off_tb
